// ===== rs_exec_core.sv
// Decode and execute of control-flow and return-stack instructions
//
// Behaviour
// RQ1: 0x0006 discards stack top, one cycle
// RQ2: Discard pops top; older entry becomes top
// RQ3: 0x0005 saves next address, one cycle
// RQ4: Save pushes counter plus two
// RQ5: Relative call pattern, 11-bit offset, two cycles
// RQ6: Call pushes counter+2, jumps counter+2+2n
// RQ7: Interrupt return, bit0 selects shadow restore
// RQ8: Interrupt return pops into counter
// RQ9: Interrupt return sets high or low enable
// RQ10: Shadow restore loads accumulator, flags, bank
// RQ11: Literal return carries 8-bit literal, two cycles
// RQ12: Literal return writes accumulator, pops counter
// RQ13: 0x00FF is software restart, one cycle
// RQ14: Restart returns all state to reset values
// RQ15: Zero word or top nibble F: no effect
`default_nettype none

module rs_exec_core #(
  parameter int DEPTH = rs_exec_pkg::DEPTH
) (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             srst,
  // Instruction stream
  input  wire logic                             instr_valid,
  input  wire logic [rs_exec_pkg::WORD_W-1:0]   instr_word,
  output var  logic                             fetch_ready_reg,
  // Interrupt controller side
  input  wire logic                             priority_mode,
  input  wire logic [1:0]                       irq_enable_clear,
  input  wire logic [rs_exec_pkg::DATA_W-1:0]   accumulator_shadow,
  input  wire logic [rs_exec_pkg::STAT_W-1:0]   flags_shadow,
  input  wire logic [rs_exec_pkg::DATA_W-1:0]   bank_select_shadow,
  // Architectural state
  output var  logic [rs_exec_pkg::PC_W-1:0]     program_counter_reg,
  output var  logic [rs_exec_pkg::PC_W-1:0]     stack_top_entry_reg,
  output var  logic [rs_exec_pkg::DATA_W-1:0]   accumulator_reg,
  output var  logic [rs_exec_pkg::STAT_W-1:0]   status_reg,
  output var  logic [rs_exec_pkg::DATA_W-1:0]   bank_select_reg,
  output var  logic [1:0]                       irq_enable_reg,
  output var  logic                             restart_pulse_reg
);

  // ==========================================================
  // Local sizes
  // ==========================================================
  localparam int ENTRIES = DEPTH - 1;           // Levels below the top
  localparam int AW      = $clog2(ENTRIES);     // Memory address width
  localparam int CW      = $clog2(ENTRIES + 1); // Level count width
  localparam int PC_W    = rs_exec_pkg::PC_W;
  localparam int DATA_W  = rs_exec_pkg::DATA_W;
  localparam int STAT_W  = rs_exec_pkg::STAT_W;

  // Refuse a stack too shallow for a top plus two stored levels
  if (DEPTH < 3) begin : g_depth_check
    $error("rs_exec_core: DEPTH must be at least 3");
  end

  // ==========================================================
  // State
  // ==========================================================
  logic [PC_W-1:0]   pc_next;          // Next program counter
  logic [PC_W-1:0]   top_next;         // Next stack top
  logic              top_valid_reg;    // Stack top holds an entry
  logic              top_valid_next;
  logic [CW-1:0]     level_reg;        // Entries held in memory
  logic [CW-1:0]     level_next;
  logic [DATA_W-1:0] acc_next;         // Next accumulator
  logic [STAT_W-1:0] status_next;      // Next status
  logic [DATA_W-1:0] bank_next;        // Next bank select
  logic [1:0]        irq_next;         // Next interrupt enables
  logic              busy_next;        // Next cycle is a refused cycle
  logic              ready_next;       // Next fetch ready
  logic              restart_next;     // Restart pulse next
  logic              take;             // Instruction accepted
  rs_exec_pkg::op_kind_t kind;         // Decoded operation

  // Stack memory ports
  logic              mem_we;           // Push writes old top
  logic [AW-1:0]     mem_waddr;        // Write address
  logic [AW-1:0]     mem_raddr;        // Address of next-below entry
  logic [PC_W-1:0]   below_top;        // Entry just below the top

  // Sign-extended call displacement, doubled
  logic [PC_W-1:0]   call_disp;
  logic [PC_W-1:0]   ret_addr;         // Counter plus two

  // ==========================================================
  // Decode
  // ==========================================================
  // Classify the word into one operation kind
  always_comb begin
    if (instr_word == rs_exec_pkg::OPC_NOP_ZERO ||
        instr_word[15:12] == rs_exec_pkg::OPC_NOP_NIB) begin
      kind = rs_exec_pkg::K_NOP;                                // [RQ15]
    end else if (instr_word == rs_exec_pkg::OPC_DISCARD) begin
      kind = rs_exec_pkg::K_DISCARD;                            // [RQ1]
    end else if (instr_word == rs_exec_pkg::OPC_SAVE) begin
      kind = rs_exec_pkg::K_SAVE;                               // [RQ3]
    end else if (instr_word[15:11] == rs_exec_pkg::OPC_CALL_HI) begin
      kind = rs_exec_pkg::K_CALL;                               // [RQ5]
    end else if (instr_word[15:1] == rs_exec_pkg::OPC_IRET_HI) begin
      kind = rs_exec_pkg::K_IRET;                               // [RQ7]
    end else if (instr_word[15:8] == rs_exec_pkg::OPC_RETLIT_HI) begin
      kind = rs_exec_pkg::K_RETLIT;                             // [RQ11]
    end else if (instr_word == rs_exec_pkg::OPC_RESTART) begin
      kind = rs_exec_pkg::K_RESTART;                            // [RQ13]
    end else begin
      kind = rs_exec_pkg::K_OTHER;
    end
  end

  // Offset n times two, sign-extended to the counter width
  assign call_disp = {{(PC_W - rs_exec_pkg::OFS_W - 1){instr_word[10]}},
                      instr_word[10:0], 1'b0};                  // [RQ6]
  assign ret_addr  = program_counter_reg + rs_exec_pkg::PC_STEP;
  assign take      = instr_valid && fetch_ready_reg;

  // ==========================================================
  // Execute
  // ==========================================================
  // Compute every next value from the accepted instruction
  always_comb begin
    pc_next        = program_counter_reg;
    top_next       = stack_top_entry_reg;
    top_valid_next = top_valid_reg;
    level_next     = level_reg;
    acc_next       = accumulator_reg;
    status_next    = status_reg;
    bank_next      = bank_select_reg;
    irq_next       = irq_enable_reg & ~irq_enable_clear;
    busy_next      = 1'b0;
    restart_next   = 1'b0;
    mem_we         = 1'b0;
    if (take) begin
      unique case (kind)
        rs_exec_pkg::K_NOP,
        rs_exec_pkg::K_OTHER: begin
          // Only the counter advances
          pc_next = ret_addr;                                   // [RQ15]
        end
        rs_exec_pkg::K_DISCARD: begin
          // Drop the top; the older entry rises
          pc_next = ret_addr;
          if (level_reg != '0) begin
            top_next   = below_top;                             // [RQ2]
            level_next = level_reg - CW'(1);
          end else begin
            top_next       = rs_exec_pkg::PC_RST;
            top_valid_next = 1'b0;
          end
        end
        rs_exec_pkg::K_SAVE: begin
          // Push the next address
          pc_next = ret_addr;
          {mem_we, top_valid_next} = {top_valid_reg, 1'b1};
          top_next = ret_addr;                                  // [RQ4]
          if (top_valid_reg && level_reg != CW'(ENTRIES)) begin
            level_next = level_reg + CW'(1);
          end
        end
        rs_exec_pkg::K_CALL: begin
          // Push return address, then jump relative
          {mem_we, top_valid_next} = {top_valid_reg, 1'b1};
          top_next  = ret_addr;                                 // [RQ6]
          pc_next   = ret_addr + call_disp;                     // [RQ6]
          busy_next = 1'b1;                                     // [RQ5]
          if (top_valid_reg && level_reg != CW'(ENTRIES)) begin
            level_next = level_reg + CW'(1);
          end
        end
        rs_exec_pkg::K_IRET,
        rs_exec_pkg::K_RETLIT: begin
          // Pop the top into the counter; then set an interrupt enable or load the literal
          pc_next   = stack_top_entry_reg;                      // [RQ8] [RQ12]
          busy_next = 1'b1;                                     // [RQ7] [RQ11]
          if (level_reg != '0) begin
            top_next   = below_top;
            level_next = level_reg - CW'(1);
          end else begin
            top_next       = rs_exec_pkg::PC_RST;
            top_valid_next = 1'b0;
          end
          if (kind == rs_exec_pkg::K_RETLIT) begin
            acc_next = instr_word[7:0];                         // [RQ12]
          end else begin
            // Set wins over a same-cycle clear from the controller
            if (!priority_mode || !irq_enable_reg[rs_exec_pkg::IRQ_HI]) begin
              irq_next[rs_exec_pkg::IRQ_HI] = 1'b1;             // [RQ9]
            end else begin
              irq_next[rs_exec_pkg::IRQ_LO] = 1'b1;             // [RQ9]
            end
            if (instr_word[rs_exec_pkg::SHADOW_BIT]) begin
              acc_next    = accumulator_shadow;                 // [RQ10]
              status_next = flags_shadow;                       // [RQ10]
              bank_next   = bank_select_shadow;                 // [RQ10]
            end
          end
        end
        rs_exec_pkg::K_RESTART: begin
          // Same state as an external master clear
          pc_next        = rs_exec_pkg::PC_RST;                 // [RQ14]
          top_next       = rs_exec_pkg::PC_RST;
          top_valid_next = 1'b0;
          level_next     = '0;
          acc_next       = rs_exec_pkg::W_RST;
          status_next    = rs_exec_pkg::STAT_RST;
          bank_next      = rs_exec_pkg::BANK_RST;
          irq_next       = rs_exec_pkg::IRQ_RST;
          restart_next   = 1'b1;                                // [RQ13]
        end
      endcase
    end
    ready_next = !busy_next;
  end

  // Register the architectural state
  always_ff @(posedge clk) begin
    if (srst) begin
      program_counter_reg <= rs_exec_pkg::PC_RST;
      stack_top_entry_reg <= rs_exec_pkg::PC_RST;
      top_valid_reg       <= 1'b0;
      level_reg           <= '0;
      accumulator_reg     <= rs_exec_pkg::W_RST;
      status_reg          <= rs_exec_pkg::STAT_RST;
      bank_select_reg     <= rs_exec_pkg::BANK_RST;
      irq_enable_reg      <= rs_exec_pkg::IRQ_RST;
      fetch_ready_reg     <= 1'b0;
      restart_pulse_reg   <= 1'b0;
    end else begin
      program_counter_reg <= pc_next;
      stack_top_entry_reg <= top_next;
      top_valid_reg       <= top_valid_next;
      level_reg           <= level_next;
      accumulator_reg     <= acc_next;
      status_reg          <= status_next;
      bank_select_reg     <= bank_next;
      irq_enable_reg      <= irq_next;
      fetch_ready_reg     <= ready_next;
      restart_pulse_reg   <= restart_next;
    end
  end

  // ==========================================================
  // Stack storage
  // ==========================================================
  // Old top lands at the current level; a full stack drops it
  assign mem_waddr = (level_reg == CW'(ENTRIES)) ?
                     AW'(ENTRIES - 1) : level_reg[AW-1:0];
  // Keep the entry just below the next top in the read register
  assign mem_raddr = (level_next == '0) ? '0 :
                     AW'(level_next - CW'(1));

  rs_stack_mem #(
    .WIDTH   (PC_W),
    .ENTRIES (ENTRIES),
    .AW      (AW)
  ) u_stack (
    .clk         (clk),
    .wr_en       (mem_we && level_reg != CW'(ENTRIES)),
    .wr_addr     (mem_waddr),
    .wr_data     (stack_top_entry_reg),
    .rd_addr     (mem_raddr),
    .rd_data_reg (below_top)
  );

endmodule

`default_nettype wire

// ===== rs_exec_pkg.sv
// Shared constants and types for the return-stack instruction executor
`default_nettype none

package rs_exec_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int PC_W   = 21;  // Program counter width
  localparam int WORD_W = 16;  // Instruction word width
  localparam int DATA_W = 8;   // Accumulator and bank width
  localparam int STAT_W = 5;   // Status register width
  localparam int DEPTH  = 31;  // Return stack levels

  // ==========================================================
  // Opcodes and field positions
  // ==========================================================
  localparam logic [15:0] OPC_NOP_ZERO  = 16'h0000;
  localparam logic [15:0] OPC_DISCARD   = 16'h0006;
  localparam logic [15:0] OPC_SAVE      = 16'h0005;
  localparam logic [15:0] OPC_RESTART   = 16'h00FF;
  localparam logic [14:0] OPC_IRET_HI   = 15'h0008;  // Word bits 15:1
  localparam logic [7:0]  OPC_RETLIT_HI = 8'h0C;     // Word bits 15:8
  localparam logic [4:0]  OPC_CALL_HI   = 5'h1B;     // Word bits 15:11
  localparam logic [3:0]  OPC_NOP_NIB   = 4'hF;      // Word bits 15:12
  localparam int          OFS_W         = 11;        // Call offset width
  localparam int          SHADOW_BIT    = 0;         // Shadow select bit

  // ==========================================================
  // Reset values and steps
  // ==========================================================
  localparam logic [PC_W-1:0]   PC_RST   = 21'h0_0000;
  localparam logic [PC_W-1:0]   PC_STEP  = 21'h0_0002;
  localparam logic [DATA_W-1:0] W_RST    = 8'h00;
  localparam logic [DATA_W-1:0] BANK_RST = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
  localparam logic [1:0]        IRQ_RST  = 2'h0;
  localparam int                IRQ_HI   = 0;  // High / global enable
  localparam int                IRQ_LO   = 1;  // Low / peripheral enable

  // Decoded operation kinds
  typedef enum logic [2:0] {
    K_NOP, K_DISCARD, K_SAVE, K_CALL, K_IRET, K_RETLIT, K_RESTART, K_OTHER
  } op_kind_t;

endpackage

`default_nettype wire

// ===== rs_stack_mem.sv
// Return stack storage with registered, write-through read data
`default_nettype none

module rs_stack_mem #(
  parameter int WIDTH   = 21,
  parameter int ENTRIES = 30,
  parameter int AW      = 5
) (
  // Clock
  input  wire logic             clk,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [WIDTH-1:0] rd_data_reg
);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [WIDTH-1:0] mem [ENTRIES];  // Stored lower levels
  logic [WIDTH-1:0] rd_data_next;   // Read value before register

  // Refuse a depth that the address width cannot reach
  if (ENTRIES < 1 || ENTRIES > (1 << AW)) begin : g_size_check
    $error("rs_stack_mem: ENTRIES does not fit AW");
  end

  // Forward a same-cycle write so the read never sees stale data
  always_comb begin
    if (wr_en && wr_addr == rd_addr) begin
      rd_data_next = wr_data;
    end else begin
      rd_data_next = mem[rd_addr];
    end
  end

  // Write and read registers
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= rd_data_next;
  end

endmodule

`default_nettype wire

// ===== rs_exec_core_assertions.sv
// Concurrent checks on the return-stack executor ports
`default_nettype none

module rs_exec_core_assertions #(
  parameter int DEPTH = 31
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Instruction stream
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        fetch_ready_reg,
  // Interrupt controller side
  input wire logic        priority_mode,
  input wire logic [1:0]  irq_enable_clear,
  input wire logic [7:0]  accumulator_shadow,
  input wire logic [4:0]  flags_shadow,
  input wire logic [7:0]  bank_select_shadow,
  // Architectural state
  input wire logic [20:0] program_counter_reg,
  input wire logic [20:0] stack_top_entry_reg,
  input wire logic [7:0]  accumulator_reg,
  input wire logic [4:0]  status_reg,
  input wire logic [7:0]  bank_select_reg,
  input wire logic [1:0]  irq_enable_reg,
  input wire logic        restart_pulse_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Decode helpers
  // ==========================================================
  logic        take;      // Word accepted at this edge
  logic        is_disc;   // Discard top
  logic        is_save;   // Save next address
  logic        is_rst;    // Software restart
  logic        is_call;   // Relative call
  logic        is_iret;   // Interrupt return
  logic        is_rlit;   // Literal return
  logic        is_nop;    // No-effect word
  logic [20:0] call_ofs;  // Signed offset times two
  logic [20:0] pc;        // Short alias
  logic [20:0] top;       // Short alias
  logic [20:0] stp;       // Counter step
  assign take     = instr_valid && fetch_ready_reg;
  assign is_disc  = instr_word == rs_exec_pkg::OPC_DISCARD;
  assign is_save  = instr_word == rs_exec_pkg::OPC_SAVE;
  assign is_rst   = instr_word == rs_exec_pkg::OPC_RESTART;
  assign is_call  = instr_word[15:11] == rs_exec_pkg::OPC_CALL_HI;
  assign is_iret  = instr_word[15:1] == rs_exec_pkg::OPC_IRET_HI;
  assign is_rlit  = instr_word[15:8] == rs_exec_pkg::OPC_RETLIT_HI;
  assign is_nop   = instr_word == 16'h0000 || instr_word[15:12] == 4'hF;
  assign call_ofs = {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
  assign pc       = program_counter_reg;
  assign top      = stack_top_entry_reg;
  assign stp      = rs_exec_pkg::PC_STEP;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // One refused cycle, then ready again
  sequence s_gap;
    !fetch_ready_reg ##1 fetch_ready_reg;
  endsequence
  // A two-cycle operation is taken
  sequence s_take2;
    take && (is_call || is_iret || is_rlit);
  endsequence

  a_two_cycle_gap: assert property (s_take2 |=> s_gap)
    else $error("two-cycle op without one refused cycle");
  a_one_cycle_op: assert property (take && (is_disc || is_save || is_rst
    || is_nop) |=> fetch_ready_reg)
    else $error("one-cycle op stalled the fetch");
  a_save_push: assert property (take && is_save |=> top == $past(pc) + stp
    && pc == $past(pc) + stp)
    else $error("save did not push next address");
  a_discard_step: assert property (take && is_disc |=>
    pc == $past(pc) + stp)
    else $error("discard moved counter wrongly");
  a_call_target: assert property (take && is_call |=> top == $past(pc) + stp
    && pc == $past(pc) + stp + $past(call_ofs))
    else $error("relative call target or return address wrong");
  a_retlit_load: assert property (take && is_rlit |=>
    accumulator_reg == $past(instr_word[7:0]) && pc == $past(top))
    else $error("literal return wrong");
  a_iret_pop: assert property (take && is_iret |=> pc == $past(top))
    else $error("interrupt return did not pop counter");
  a_shadow_load: assert property (take && is_iret && instr_word[0] |=>
    accumulator_reg == $past(accumulator_shadow)
    && status_reg == $past(flags_shadow)
    && bank_select_reg == $past(bank_select_shadow))
    else $error("shadow restore missing");
  a_shadow_keep: assert property (take && is_iret && !instr_word[0] |=>
    $stable(accumulator_reg) && $stable(status_reg)
    && $stable(bank_select_reg))
    else $error("state changed without shadow select");
  a_irq_reenable: assert property (take && is_iret && !priority_mode |=>
    irq_enable_reg[0])
    else $error("global enable not set by interrupt return");
  a_restart_state: assert property (take && is_rst |=> restart_pulse_reg
    && pc == 21'h0_0000 && top == 21'h0_0000 && accumulator_reg == 8'h00
    && status_reg == 5'h00 && irq_enable_reg == 2'h0)
    else $error("restart left state set");
  a_nop_still: assert property (take && is_nop |=> pc == $past(pc) + stp
    && $stable(top) && $stable(accumulator_reg)
    && $stable(status_reg))
    else $error("no-effect word changed state");
  a_refused_hold: assert property (instr_valid && !fetch_ready_reg |=>
    $stable(pc) && $stable(top))
    else $error("word in refused cycle was executed");
endmodule

bind rs_exec_core rs_exec_core_assertions #(.DEPTH(DEPTH))
  i_rs_exec_core_assertions (.clk, .srst, .instr_valid, .instr_word,
  .fetch_ready_reg, .priority_mode, .irq_enable_clear, .accumulator_shadow,
  .flags_shadow, .bank_select_shadow, .program_counter_reg,
  .stack_top_entry_reg, .accumulator_reg, .status_reg, .bank_select_reg,
  .irq_enable_reg, .restart_pulse_reg);

`default_nettype wire

// ===== rs_fetch_model.sv
// Program memory model feeding queued words to the executor
`default_nettype none

module rs_fetch_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Instruction stream
  input  wire logic        fetch_ready_reg,
  output var  logic        instr_valid,
  output var  logic [15:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] q[$];     // Words still to hand over
  logic [15:0] last;     // Last word shown
  logic        rst_seen; // Reset sampled at the edge

  function automatic void put(input logic [15:0] w);
    q.push_back(w);
  endfunction
  function automatic int pending();
    return q.size();
  endfunction

  initial begin
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    last        = 16'h0000;
  end
  // Retire a taken word, then show the next one just after the edge
  always @(posedge clk) begin
    rst_seen = srst;
    if (!srst && instr_valid && fetch_ready_reg) void'(q.pop_front());
    #1;
    if (q.size() != 0 && !rst_seen) begin
      instr_valid = 1'b1;
      instr_word  = q[0];
      last        = q[0];
    end else begin
      // Released bus shows no stale word
      instr_valid = 1'b0;
      instr_word  = ~last;
    end
  end
endmodule

`default_nettype wire

// ===== return_stack_control_instr_exec_tb.sv
// Self-checking bench for the return-stack executor
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module return_stack_control_instr_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals and reference state
  // ==========================================================
  logic        clk, srst, priority_mode, instr_valid, fetch_ready_reg;
  logic        restart_pulse_reg, tk;
  logic [1:0]  irq_enable_clear, irq_enable_reg, irq_m, set_b, clr;
  logic [15:0] instr_word, w;
  logic [7:0]  accumulator_shadow, bank_select_shadow, sa, sb;
  logic [7:0]  accumulator_reg, bank_select_reg, acc_m, bank_m;
  logic [4:0]  flags_shadow, status_reg, st_m, ss;
  logic [20:0] program_counter_reg, stack_top_entry_reg, pc_m;
  logic [20:0] stk[$];   // Reference stack, top first
  logic        rdy_m, pls_m;
  int          errors, n_checks, gcount;
  localparam logic [15:0] CORNER [16] = '{16'h0000, 16'hF123, 16'h0005,
    16'h0005, 16'h0005, 16'h0006, 16'hDBFF, 16'h0C5A, 16'hDC00, 16'h0011,
    16'h0010, 16'h0006, 16'h1234, 16'h00FF, 16'h0005, 16'h0006};

  rs_exec_core #(.DEPTH(31)) i_rs_exec_core (.clk, .srst, .instr_valid,
    .instr_word, .fetch_ready_reg, .priority_mode, .irq_enable_clear,
    .accumulator_shadow, .flags_shadow, .bank_select_shadow,
    .program_counter_reg, .stack_top_entry_reg, .accumulator_reg,
    .status_reg, .bank_select_reg, .irq_enable_reg, .restart_pulse_reg);
  rs_fetch_model i_rs_fetch_model (.clk, .srst, .fetch_ready_reg,
    .instr_valid, .instr_word);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random side inputs, just after each edge
  always @(posedge clk) begin
    #1;
    irq_enable_clear   = ($urandom % 6 == 0) ? 2'($urandom) : 2'b00;
    priority_mode      = 1'($urandom);
    accumulator_shadow = 8'($urandom);
    flags_shadow       = 5'($urandom);
    bank_select_shadow = 8'($urandom);
  end

  // ==========================================================
  // Reference model and comparisons
  // ==========================================================
  function automatic logic [20:0] pop_m();
    pop_m = stk.size() != 0 ? stk[0] : 21'h0_0000;
    if (stk.size() != 0) void'(stk.pop_front());
  endfunction
  function automatic void clear_m();
    pc_m = 21'h0_0000; acc_m = 8'h00; st_m = 5'h00; bank_m = 8'h00;
    irq_m = 2'h0; stk.delete();
  endfunction
  always @(posedge clk) begin
    tk = instr_valid === 1'b1 && fetch_ready_reg === 1'b1;
    w = instr_word; clr = irq_enable_clear;
    sa = accumulator_shadow; ss = flags_shadow; sb = bank_select_shadow;
    set_b = (priority_mode && irq_m[0]) ? 2'b10 : 2'b01;
    rdy_m = !srst; pls_m = 1'b0; irq_m = irq_m & ~clr;
    if (srst) clear_m();
    else if (tk) begin
      if (w == 16'h00FF) begin clear_m(); pls_m = 1'b1; end
      else if (w == 16'h0006) begin pc_m += 2; void'(pop_m()); end
      else if (w == 16'h0005) begin pc_m += 2; stk.push_front(pc_m); end
      else if (w[15:11] == 5'h1B) begin
        stk.push_front(pc_m + 2); rdy_m = 1'b0;
        pc_m = pc_m + 2 + {{9{w[10]}}, w[10:0], 1'b0};
      end else if (w[15:1] == 15'h0008) begin
        pc_m = pop_m(); irq_m |= set_b; rdy_m = 1'b0;
        if (w[0]) begin acc_m = sa; st_m = ss; bank_m = sb; end
      end else if (w[15:8] == 8'h0C) begin
        acc_m = w[7:0]; pc_m = pop_m(); rdy_m = 1'b0;
      end else pc_m += 2;
    end
    #1;
    `CHK("pc", pc_m, program_counter_reg)
    `CHK("top", (stk.size()?stk[0]:21'h0), stack_top_entry_reg)
    `CHK("acc", acc_m, accumulator_reg)
    `CHK("status", st_m, status_reg)
    `CHK("bank", bank_m, bank_select_reg)
    `CHK("irq", irq_m, irq_enable_reg)
    `CHK("ready", rdy_m, fetch_ready_reg)
    `CHK("pulse", pls_m, restart_pulse_reg)
  end

  // ==========================================================
  // Stimulus
  // ==========================================================
  // Queue a word, keeping stack depth within 0..30
  task automatic put(input logic [15:0] x);
    int d;
    d = (x == 16'h0005 || x[15:11] == 5'h1B) ? 1 : (x == 16'h0006 ||
      x[15:1] == 15'h0008 || x[15:8] == 8'h0C) ? -1 : 0;
    if (gcount + d > 30 || gcount + d < 0) x = 16'h0000;
    else gcount += d;
    if (x == 16'h00FF) gcount = 0;
    i_rs_fetch_model.put(x);
  endtask
  function automatic logic [15:0] rnd_word();
    case ($urandom % 8)
      0: return 16'h0006;
      1: return 16'h0005;
      2: return {5'h1B, 11'($urandom)};
      3: return {15'h0008, 1'($urandom)};
      4: return {8'h0C, 8'($urandom)};
      5: return ($urandom % 4 == 0) ? 16'h00FF : 16'h0000;
      6: return {4'hF, 12'($urandom)};
      default: return 16'($urandom);
    endcase
  endfunction
  task automatic drain();
    while (i_rs_fetch_model.pending() != 0) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h7c42_deac));
    srst = 1'b1; priority_mode = 1'b0; irq_enable_clear = 2'b00;
    accumulator_shadow = 8'h00; flags_shadow = 5'h00;
    bank_select_shadow = 8'h00; errors = 0; n_checks = 0; gcount = 0;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    foreach (CORNER[i]) put(CORNER[i]);
    repeat (30) put(16'h0005);
    repeat (300) put(rnd_word());
    drain();
    // Second reset in mid-run
    srst = 1'b1;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    gcount = 0;
    repeat (200) put(rnd_word());
    drain();
    print_verdict();
  end
  // Watchdog: about twenty times the expected run of under 1000 cycles
  initial begin
    #200_000;
    errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
